/* File: core/rsc_pkg.sv */
package rsc_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned MCD_MIN_US     = 100;
  localparam int unsigned MCD_MAX_US     = 500;
  localparam int unsigned MCD_TYP_US     = 220;
  localparam int unsigned MCD_TYP_CYC    = MCD_TYP_US * CLK_MHZ;
  localparam real         RST_DELAY_US   = 5.0;
  localparam int unsigned RST_DELAY_CYC  = int'($ceil(RST_DELAY_US * CLK_MHZ));
  localparam int unsigned PIN_LOW_MIN_US = 15;
  localparam int unsigned PIN_LOW_CYC    = PIN_LOW_MIN_US * CLK_MHZ;
  localparam int unsigned WDT_DIV        = 12;

  // ==========================================================
  // Reset values and address limits
  // ==========================================================
  localparam logic [7:0]  PORT_RST_VAL   = 8'hFF;
  localparam logic [15:0] PC_RST_VAL     = 16'h0000;
  localparam logic [15:0] LIMIT_FULL     = 16'h1DFF;
  localparam logic [15:0] LIMIT_HALF     = 16'h0FFF;
  localparam logic [15:0] LIMIT_QUARTER  = 16'h07FF;
  localparam logic [1:0]  VAR_FULL       = 2'h0;
  localparam logic [1:0]  VAR_HALF       = 2'h1;
  localparam logic [1:0]  VAR_QUARTER    = 2'h2;

  // ==========================================================
  // Reset cause register bits
  // ==========================================================
  localparam int unsigned CAUSE_PIN      = 0;
  localparam int unsigned CAUSE_POR      = 1;
  localparam int unsigned CAUSE_MCD      = 2;
  localparam int unsigned CAUSE_VDD      = 3;
  localparam int unsigned CAUSE_SW       = 4;
  localparam int unsigned CAUSE_FLASH    = 6;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_RUN     = 4'h1,
    ST_RESET   = 4'h2,
    ST_DELAY   = 4'h4,
    ST_CLKWAIT = 4'h8
  } rsc_state_t;

  typedef struct packed {
    logic        valid;
    logic        program_store_write_enable;
    logic        external_data_move_instr;
    logic        code_constant_read_instr;
    logic        branch_fetch;
    logic [15:0] addr;
  } rsc_flash_acc_t;

  typedef struct packed {
    logic halt;
    logic special_function_register_init;
    logic sp_init;
    logic ram_hold;
    logic port_force;
    logic pullup_en;
    logic int_disable;
    logic timer_disable;
    logic pc_clear;
    logic clk_sel_int;
    logic wdt_enable;
    logic fetch_en;
  } rsc_core_ctl_t;

endpackage

/* File: core/rsc_pin_filter.sv */
`timescale 1ns/1ps
// ============================================================
// Reset pin low-time qualifier
// ============================================================
module rsc_pin_filter (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  input  wire logic ignore,
  output logic      req
);

  logic [rsc_pkg::CNT_W-1:0] cnt_q;
  logic [rsc_pkg::CNT_W-1:0] cnt_d;
  logic                      req_q;
  logic                      req_d;

  always_comb begin
    cnt_d = cnt_q;
    req_d = req_q;
    if (pin_in || ignore) begin
      cnt_d = '0;
      req_d = 1'b0;
    end else if (cnt_q < rsc_pkg::CNT_W'(rsc_pkg::PIN_LOW_CYC)) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      req_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      req_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      req_q <= req_d;
    end
  end

  assign req = req_q;

endmodule

/* File: core/rsc_clk_monitor.sv */
`timescale 1ns/1ps
// ============================================================
// Missing clock detector
// ============================================================
module rsc_clk_monitor #(
  parameter int unsigned TIMEOUT_CYC = rsc_pkg::MCD_TYP_CYC
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic clk_edge,
  output logic      fault
);

  logic [rsc_pkg::CNT_W-1:0] cnt_q;
  logic [rsc_pkg::CNT_W-1:0] cnt_d;
  logic                      fault_q;
  logic                      fault_d;

  always_comb begin
    cnt_d   = cnt_q;
    fault_d = fault_q;
    if (!enable || clk_edge) begin
      cnt_d   = '0;
      fault_d = 1'b0;
    end else if (cnt_q < rsc_pkg::CNT_W'(TIMEOUT_CYC)) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      fault_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      fault_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      fault_q <= fault_d;
    end
  end

  assign fault = fault_q;

endmodule

/* File: core/rsc_reset_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - While in reset, execution stops, registers load defaults, ports are forced, interrupts and timers are off.
// - Reset leaves data memory untouched while the stack pointer returns to its default.
// - Reset sets all port latches to ones in open-drain mode with weak pull-ups on during and after reset.
// - Power-on and supply-monitor resets drive the reset pin low until the device leaves reset.
// - Leaving reset clears the program counter and selects the internal oscillator.
// - Leaving reset enables the watchdog, clocked by the system clock divided by twelve.
// - After the reset delay the device waits in reset for a stable clock, then leaves reset and fetches from address zero.
// - A flash write or erase above the user code limit with the store write enable set resets the system.
// - A code-constant read above the user code limit resets the system.
// - A branch fetch above the user code limit resets the system.
// - The user code limit is fixed by memory-size variant; only the write, code-constant read and branch fetch above it are illegal.
// - A flash-error reset sets cause bit 6 and leaves the reset pin alone.
// - Writing one to cause bit 4 forces a reset that leaves the pin alone and reads back as one.
// - The missing-clock detector resets the device when core clock edges (core_clk_edge) stop for its timeout.
// - At least the reset delay passes after any source releases before code runs at address zero.
// - A reset pin held low for at least the minimum low time requests a system reset.
module rsc_reset_ctrl #(
  parameter logic [1:0]  MEM_VARIANT = rsc_pkg::VAR_FULL,
  parameter int unsigned MCD_CYC     = rsc_pkg::MCD_TYP_CYC
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   por_req,
  input  wire logic                   vdd_mon_req,
  input  wire logic                   vdd_mon_en,
  input  wire logic                   mcd_en,
  input  wire logic                   core_clk_edge,
  input  wire logic                   osc_stable,
  input  wire logic                   osc_sel_ext,
  input  wire logic                   rst_pin_i,
  output logic                        rst_pin_o,
  output logic                        rst_pin_oe,
  input  wire rsc_pkg::rsc_flash_acc_t flash_acc,
  input  wire logic                   cause_wr,
  input  wire logic [7:0]             cause_wdata,
  output logic [7:0]                  reset_cause_register,
  output rsc_pkg::rsc_core_ctl_t      core_ctl,
  output logic [7:0]                  port_latch,
  output logic [15:0]                 pc_load,
  output logic                        wdt_tick,
  output logic                        core_rst_n
);

  // ==========================================================
  // Reset release synchroniser
  // ==========================================================
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic       rst_int_n;

  always_comb begin
    rst_sync_d = {rst_sync_q[0], 1'b1};
  end

  // Assert at once, release on the second clock edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  assign rst_int_n = rst_sync_q[1];

  // ==========================================================
  // Source qualification
  // ==========================================================
  logic pin_req;
  logic mcd_fault;
  logic drive_pin_q;
  logic drive_pin_d;

  rsc_pin_filter u_pin_filter (
    .sys_clk (sys_clk),
    .rst_n   (rst_int_n),
    .pin_in  (rst_pin_i),
    .ignore  (drive_pin_q),
    .req     (pin_req)
  );

  rsc_clk_monitor #(
    .TIMEOUT_CYC (MCD_CYC)
  ) u_clk_monitor (
    .sys_clk  (sys_clk),
    .rst_n    (rst_int_n),
    .enable   (mcd_en),
    .clk_edge (core_clk_edge),
    .fault    (mcd_fault)
  );

  // ==========================================================
  // Flash access check
  // ==========================================================
  function automatic logic [15:0] code_limit(input logic [1:0] variant);
    case (variant)
      rsc_pkg::VAR_FULL:    code_limit = rsc_pkg::LIMIT_FULL;
      rsc_pkg::VAR_HALF:    code_limit = rsc_pkg::LIMIT_HALF;
      rsc_pkg::VAR_QUARTER: code_limit = rsc_pkg::LIMIT_QUARTER;
      default:              code_limit = rsc_pkg::LIMIT_QUARTER;
    endcase
  endfunction

  function automatic logic illegal_access(input rsc_pkg::rsc_flash_acc_t acc,
                                          input logic [15:0] limit);
    logic kind;
    kind = (acc.external_data_move_instr && acc.program_store_write_enable)
         || acc.code_constant_read_instr
         || acc.branch_fetch;
    illegal_access = acc.valid && kind && (acc.addr > limit);
  endfunction

  logic [15:0] limit;
  logic        in_run;
  logic        flash_err;
  logic        move_err;
  logic        read_err;
  logic        fetch_err;
  logic        sw_req;
  logic        vdd_req;
  logic        level_req;
  logic        event_req;

  assign limit     = code_limit(MEM_VARIANT);
  assign move_err  = flash_acc.external_data_move_instr
                   && flash_acc.program_store_write_enable;
  assign read_err  = flash_acc.code_constant_read_instr;
  assign fetch_err = flash_acc.branch_fetch;
  assign flash_err = in_run && (move_err || read_err || fetch_err)
                   && illegal_access(flash_acc, limit);
  assign sw_req    = in_run && cause_wr
                   && cause_wdata[rsc_pkg::CAUSE_SW];
  assign vdd_req   = vdd_mon_en && vdd_mon_req;
  assign level_req = por_req || vdd_req || pin_req || mcd_fault;
  assign event_req = flash_err || sw_req;

  // ==========================================================
  // Sequencer
  // ==========================================================
  rsc_pkg::rsc_state_t       state_q;
  rsc_pkg::rsc_state_t       state_d;
  logic [rsc_pkg::CNT_W-1:0] dly_q;
  logic [rsc_pkg::CNT_W-1:0] dly_d;
  logic                      dly_done;

  assign in_run   = (state_q == rsc_pkg::ST_RUN);
  assign dly_done = (dly_q >= rsc_pkg::CNT_W'(rsc_pkg::RST_DELAY_CYC - 1));

  always_comb begin
    state_d = state_q;
    dly_d   = dly_q;
    case (state_q)
      rsc_pkg::ST_RUN: begin
        if (level_req || event_req) begin
          state_d = rsc_pkg::ST_RESET;
        end
      end
      rsc_pkg::ST_RESET: begin
        dly_d = '0;
        if (!level_req) begin
          state_d = rsc_pkg::ST_DELAY;
        end
      end
      rsc_pkg::ST_DELAY: begin
        if (level_req) begin
          state_d = rsc_pkg::ST_RESET;
        end else if (dly_done) begin
          state_d = rsc_pkg::ST_CLKWAIT;
        end else begin
          dly_d = dly_q + 1'b1;
        end
      end
      rsc_pkg::ST_CLKWAIT: begin
        if (level_req) begin
          state_d = rsc_pkg::ST_RESET;
        end else if (osc_stable) begin
          state_d = rsc_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = rsc_pkg::ST_RESET;
        dly_d   = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      state_q <= rsc_pkg::ST_RESET;
      dly_q   <= '0;
    end else begin
      state_q <= state_d;
      dly_q   <= dly_d;
    end
  end

  // ==========================================================
  // Cause register and pin drive
  // ==========================================================
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic [7:0] cause_new;
  logic       entering;
  logic       leaving;

  assign entering = in_run && (state_d == rsc_pkg::ST_RESET);
  assign leaving  = !in_run && (state_d == rsc_pkg::ST_RUN);

  always_comb begin
    cause_new                       = '0;
    cause_new[rsc_pkg::CAUSE_PIN]   = pin_req;
    cause_new[rsc_pkg::CAUSE_POR]   = por_req;
    cause_new[rsc_pkg::CAUSE_MCD]   = mcd_fault;
    cause_new[rsc_pkg::CAUSE_VDD]   = vdd_req;
    cause_new[rsc_pkg::CAUSE_SW]    = sw_req;
    cause_new[rsc_pkg::CAUSE_FLASH] = flash_err;
    if (entering) begin
      cause_d = cause_new;
    end else if (!in_run) begin
      cause_d = cause_q | cause_new;
    end else begin
      cause_d = cause_q;
    end
  end

  always_comb begin
    drive_pin_d = drive_pin_q;
    if (por_req || vdd_req) begin
      drive_pin_d = 1'b1;
    end else if (leaving) begin
      drive_pin_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cause_q     <= 8'(1 << rsc_pkg::CAUSE_POR);
      drive_pin_q <= 1'b1;
    end else begin
      cause_q     <= cause_d;
      drive_pin_q <= drive_pin_d;
    end
  end

  // ==========================================================
  // Core controls
  // ==========================================================
  rsc_pkg::rsc_core_ctl_t ctl_q;
  rsc_pkg::rsc_core_ctl_t ctl_d;
  logic [7:0]             port_q;
  logic [7:0]             port_d;
  logic [15:0]            pc_q;
  logic [15:0]            pc_d;
  logic                   run_next;

  assign run_next = (state_d == rsc_pkg::ST_RUN);

  always_comb begin
    ctl_d                                = ctl_q;
    ctl_d.halt                           = !run_next;
    ctl_d.special_function_register_init = !run_next;
    ctl_d.sp_init                        = !run_next;
    ctl_d.ram_hold                       = !run_next;
    ctl_d.port_force                     = !run_next;
    ctl_d.pullup_en                      = 1'b1;
    ctl_d.int_disable                    = !run_next;
    ctl_d.timer_disable                  = !run_next;
    ctl_d.pc_clear                       = leaving;
    ctl_d.fetch_en                       = run_next;
    if (!run_next) begin
      ctl_d.clk_sel_int = 1'b1;
      ctl_d.wdt_enable  = 1'b0;
    end else if (leaving) begin
      ctl_d.clk_sel_int = 1'b1;
      ctl_d.wdt_enable  = 1'b1;
    end else begin
      ctl_d.clk_sel_int = !osc_sel_ext;
    end
    port_d = run_next ? port_q : rsc_pkg::PORT_RST_VAL;
    pc_d   = run_next ? pc_q : rsc_pkg::PC_RST_VAL;
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ctl_q                                <= '0;
      ctl_q.halt                           <= 1'b1;
      ctl_q.special_function_register_init <= 1'b1;
      ctl_q.sp_init                        <= 1'b1;
      ctl_q.ram_hold                       <= 1'b1;
      ctl_q.port_force                     <= 1'b1;
      ctl_q.pullup_en                      <= 1'b1;
      ctl_q.int_disable                    <= 1'b1;
      ctl_q.timer_disable                  <= 1'b1;
      ctl_q.clk_sel_int                    <= 1'b1;
      port_q                               <= rsc_pkg::PORT_RST_VAL;
      pc_q                                 <= rsc_pkg::PC_RST_VAL;
    end else begin
      ctl_q  <= ctl_d;
      port_q <= port_d;
      pc_q   <= pc_d;
    end
  end

  // ==========================================================
  // Watchdog clock divider
  // ==========================================================
  logic [3:0] div_q;
  logic [3:0] div_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    div_d  = '0;
    tick_d = 1'b0;
    if (ctl_q.wdt_enable) begin
      if (div_q == 4'(rsc_pkg::WDT_DIV - 1)) begin
        tick_d = 1'b1;
      end else begin
        div_d = div_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign reset_cause_register = cause_q;
  assign core_ctl             = ctl_q;
  assign port_latch           = port_q;
  assign pc_load              = pc_q;
  assign wdt_tick             = tick_q;
  assign core_rst_n           = !ctl_q.halt;
  assign rst_pin_o            = 1'b0;
  assign rst_pin_oe           = drive_pin_q;

endmodule

/* File: verif/rsc_pin_agent.sv */
`timescale 1ns/1ps
// ========================================
// Reset pin wire with pull-up
module rsc_pin_agent (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic pull_low,
  output logic      pin_i
);
  // Pull-up unless the device or the agent pulls low
  assign pin_i = (pin_oe ? pin_o : 1'b1) && !pull_low;
endmodule

/* File: verif/rsc_reset_ctrl_checker.sv */
`timescale 1ns/1ps
module rsc_reset_ctrl_checker #(
  parameter logic [1:0]  MEM_VARIANT = rsc_pkg::VAR_FULL,
  parameter int unsigned MCD_CYC     = rsc_pkg::MCD_TYP_CYC
) (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    por_req,
  input wire logic                    vdd_mon_req,
  input wire logic                    vdd_mon_en,
  input wire logic                    mcd_en,
  input wire logic                    core_clk_edge,
  input wire logic                    osc_stable,
  input wire logic                    osc_sel_ext,
  input wire logic                    rst_pin_i,
  input wire logic                    rst_pin_o,
  input wire logic                    rst_pin_oe,
  input wire rsc_pkg::rsc_flash_acc_t flash_acc,
  input wire logic                    cause_wr,
  input wire logic [7:0]              cause_wdata,
  input wire logic [7:0]              reset_cause_register,
  input wire rsc_pkg::rsc_core_ctl_t  core_ctl,
  input wire logic [7:0]              port_latch,
  input wire logic [15:0]             pc_load,
  input wire logic                    wdt_tick,
  input wire logic                    core_rst_n
);
  // ========================================
  // Helper counters
  localparam int DLY = 500;
  localparam logic [15:0] LIM = (MEM_VARIANT == rsc_pkg::VAR_HALF) ? rsc_pkg::LIMIT_HALF :
    (MEM_VARIANT == rsc_pkg::VAR_QUARTER) ? rsc_pkg::LIMIT_QUARTER : rsc_pkg::LIMIT_FULL;
  logic [15:0] lo_q, lo_d, pl_q, pl_d, gap_q, gap_d;
  logic [7:0]  wc_q, wc_d;
  logic        bad;
  assign bad = flash_acc.valid && flash_acc.addr > LIM && (flash_acc.code_constant_read_instr
    || flash_acc.branch_fetch
    || (flash_acc.external_data_move_instr && flash_acc.program_store_write_enable));
  always_comb begin
    lo_d  = core_rst_n ? 16'h0000 : lo_q + 16'h0001;
    pl_d  = rst_pin_i ? 16'h0000 : pl_q + 16'(pl_q != 16'hFFFF);
    gap_d = (core_clk_edge || !mcd_en) ? 16'h0000 : gap_q + 16'(gap_q != 16'hFFFF);
    wc_d  = !core_ctl.wdt_enable ? 8'hFF : wdt_tick ? 8'h00 : wc_q + 8'(wc_q != 8'hFF);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q  <= 16'h0000;
      pl_q  <= 16'h0000;
      gap_q <= 16'h0000;
      wc_q  <= 8'hFF;
    end else begin
      lo_q  <= lo_d;
      pl_q  <= pl_d;
      gap_q <= gap_d;
      wc_q  <= wc_d;
    end
  end
  // ========================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence exit_s;
    !core_rst_n ##1 core_rst_n;
  endsequence
  sequence soft_s;
    core_rst_n && cause_wr && cause_wdata[4];
  endsequence
  hold_in_reset_a: assert property (!core_rst_n |-> core_ctl.halt && core_ctl.sp_init
    && core_ctl.special_function_register_init && core_ctl.ram_hold && core_ctl.port_force
    && core_ctl.int_disable && core_ctl.timer_disable && !core_ctl.fetch_en
    && port_latch == 8'hFF && pc_load == 16'h0000) else $error("reset state wrong");
  pullup_kept_a: assert property (core_ctl.pullup_en) else $error("pull-up off");
  pin_drive_a: assert property (por_req || (vdd_mon_req && vdd_mon_en) |=>
    rst_pin_oe && !rst_pin_o && !core_rst_n) else $error("pin not driven low");
  exit_values_a: assert property (exit_s |-> core_ctl.pc_clear && core_ctl.clk_sel_int
    && core_ctl.wdt_enable && core_ctl.fetch_en && pc_load == 16'h0000) else $error("exit bad");
  wdt_period_a: assert property (core_ctl.wdt_enable && wc_q < 8'h0C |->
    wdt_tick == (wc_q == 8'h0B)) else $error("watchdog tick spacing");
  flash_reset_a: assert property (core_rst_n && bad |=> !core_rst_n
    && reset_cause_register[6]) else $error("flash fault not reset");
  soft_reset_a: assert property (soft_s |=> !core_rst_n && reset_cause_register[4])
    else $error("soft reset missed");
  exit_delay_a: assert property (exit_s |-> lo_q >= DLY) else $error("exit too early");
  clk_wait_a: assert property (!core_rst_n && !osc_stable |=> !core_rst_n)
    else $error("left reset on unstable clock");
  mcd_fault_a: assert property (gap_q > MCD_CYC + 3 |-> !core_rst_n) else $error("no clock reset");
  pin_request_a: assert property (pl_q > 16'h05E6 |-> !core_rst_n) else $error("pin reset missed");
endmodule
bind rsc_reset_ctrl rsc_reset_ctrl_checker #(.MEM_VARIANT(MEM_VARIANT), .MCD_CYC(MCD_CYC)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .por_req(por_req), .vdd_mon_req(vdd_mon_req),
  .vdd_mon_en(vdd_mon_en), .mcd_en(mcd_en), .core_clk_edge(core_clk_edge),
  .osc_stable(osc_stable), .osc_sel_ext(osc_sel_ext), .rst_pin_i(rst_pin_i),
  .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .flash_acc(flash_acc), .cause_wr(cause_wr),
  .cause_wdata(cause_wdata), .reset_cause_register(reset_cause_register),
  .core_ctl(core_ctl), .port_latch(port_latch), .pc_load(pc_load), .wdt_tick(wdt_tick),
  .core_rst_n(core_rst_n));

/* File: verif/tb_reset_source_controller.sv */
`timescale 1ns/1ps
module tb_reset_source_controller;
  localparam int unsigned MCD = 50;
  logic sys_clk = 1'b0, rst_n = 1'b0, por_req = 1'b0, vdd_mon_req = 1'b0, vdd_mon_en = 1'b0;
  logic mcd_en = 1'b0, core_clk_edge = 1'b1, osc_stable = 1'b0, ext_low = 1'b0, cause_wr = 1'b0;
  logic                    rst_pin_i, rst_pin_o, rst_pin_oe, wdt_tick, core_rst_n;
  logic                    osc_ext = 1'b0;
  logic [7:0]              cause_wdata = 8'h00;
  logic [7:0]              reset_cause_register, port_latch;
  logic [15:0]             pc_load;
  rsc_pkg::rsc_flash_acc_t flash_acc = '0;
  rsc_pkg::rsc_core_ctl_t  core_ctl;
  int                      n_mismatch = 0, samples_checked = 0, n, k;
  // Rows: expected reset, then access fields and address
  logic [21:0] rows [7] = '{22'h120FFF, 22'h321000, 22'h311000, 22'h110FFF, 22'h3C1000,
                            22'h141FFF, 22'h02FFFF};

  rsc_reset_ctrl #(.MEM_VARIANT(rsc_pkg::VAR_HALF), .MCD_CYC(MCD)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .por_req(por_req), .vdd_mon_req(vdd_mon_req),
    .vdd_mon_en(vdd_mon_en), .mcd_en(mcd_en), .core_clk_edge(core_clk_edge),
    .osc_stable(osc_stable), .osc_sel_ext(osc_ext), .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .flash_acc(flash_acc), .cause_wr(cause_wr),
    .cause_wdata(cause_wdata), .reset_cause_register(reset_cause_register),
    .core_ctl(core_ctl), .port_latch(port_latch), .pc_load(pc_load), .wdt_tick(wdt_tick),
    .core_rst_n(core_rst_n));
  rsc_pin_agent u_pin (.pin_o(rst_pin_o), .pin_oe(rst_pin_oe), .pull_low(ext_low),
    .pin_i(rst_pin_i));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ========================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  task automatic wait_run(input int pre = 0);
    n = 0;
    while (core_rst_n !== 1'b1 && n < 3000) begin
      cyc(1);
      n++;
    end
    check(16'((n + pre) > 490), 16'h0001);
    check(16'({core_ctl.pc_clear, core_ctl.clk_sel_int, core_ctl.wdt_enable, core_ctl.fetch_en}),
          16'h000F);
  endtask
  task automatic pulse_wr(input logic [7:0] d);
    cause_wr = 1'b1;
    cause_wdata = d;
    cyc(1);
    cause_wr = 1'b0;
    cyc(1);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #300000;
    n_mismatch++;
    complete_run();
  end

  // ========================================
  // Sequence
  initial begin
    cyc(11);
    check(16'({core_rst_n, rst_pin_oe, rst_pin_i, core_ctl.wdt_enable}), 16'h0004);
    check(16'(port_latch), 16'h00FF);
    cyc(1);
    rst_n = 1'b1;
    cyc(700);
    check(16'(core_rst_n), 16'h0000);
    osc_stable = 1'b1;
    wait_run(700);
    check(16'(reset_cause_register), 16'h0002);
    k = 0;
    repeat (120) begin
      cyc(1);
      k += int'(wdt_tick === 1'b1);
    end
    check(16'(k), 16'h000A);
    foreach (rows[i]) begin
      flash_acc = rsc_pkg::rsc_flash_acc_t'(rows[i][20:0]);
      cyc(1);
      flash_acc = '0;
      cyc(1);
      check(16'(core_rst_n), 16'(!rows[i][21]));
      if (rows[i][21]) begin
        check(16'({reset_cause_register, rst_pin_i}), 16'h0081);
        wait_run();
      end
    end
    pulse_wr(8'hEF);
    check(16'(core_rst_n), 16'h0001);
    pulse_wr(8'h10);
    check(16'({core_rst_n, rst_pin_i}), 16'h0001);
    wait_run();
    check(16'(reset_cause_register), 16'h0010);
    por_req = 1'b1;
    cyc(20);
    check(16'({core_rst_n, rst_pin_oe, rst_pin_i}), 16'h0002);
    por_req = 1'b0;
    wait_run();
    check(16'({reset_cause_register, rst_pin_i}), 16'h0005);
    vdd_mon_req = 1'b1;
    cyc(5);
    check(16'(core_rst_n), 16'h0001);
    vdd_mon_en = 1'b1;
    cyc(3);
    check(16'({core_rst_n, rst_pin_i}), 16'h0000);
    vdd_mon_req = 1'b0;
    wait_run();
    check(16'(reset_cause_register), 16'h0008);
    mcd_en = 1'b1;
    core_clk_edge = 1'b0;
    cyc(MCD - 10);
    check(16'(core_rst_n), 16'h0001);
    cyc(20);
    check(16'(core_rst_n), 16'h0000);
    core_clk_edge = 1'b1;
    wait_run();
    check(16'(reset_cause_register), 16'h0004);
    ext_low = 1'b1;
    cyc(1000);
    check(16'(core_rst_n), 16'h0001);
    ext_low = 1'b0;
    cyc(2);
    ext_low = 1'b1;
    cyc(1510);
    check(16'({core_rst_n, reset_cause_register}), 16'h0001);
    ext_low = 1'b0;
    wait_run();
    osc_ext = 1'b1;
    cyc(2);
    check(16'(core_ctl.clk_sel_int), 16'h0000);
    rst_n = 1'b0;
    cyc(2);
    check(16'({core_rst_n, rst_pin_oe, core_ctl.clk_sel_int, reset_cause_register}),
          16'h0302);
    rst_n = 1'b1;
    wait_run();
    check(16'({reset_cause_register, rst_pin_i}), 16'h0005);
    complete_run();
  end
endmodule
